/* axi_wr_model.sv */
module axi_wr_model (
	input  logic       clk_i,
	input  logic       rst_i,
	input  logic       awvalid_i,
	input  logic       wvalid_i,
	input  logic       wlast_i,
	input  logic       bready_i,
	input  logic [3:0] awlen_i,
	output logic       awready_o,
	output logic       wready_o,
	output logic       bvalid_o,
	output logic [1:0] bresp_o,
	output logic [3:0] len_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] slow_r;
	// ready two cycles in four, so the store path can meet back pressure
	assign awready_o = slow_r[0];
	assign wready_o = slow_r[1];
	assign bresp_o = 2'h0;
	// response held until taken
	always_ff @(posedge clk_i) begin
		slow_r <= rst_i ? 2'h0 : slow_r + 2'h1;
		if (awvalid_i && awready_o)
			len_seen_o <= awlen_i;
		if (rst_i || (bvalid_o && bready_i))
			bvalid_o <= 1'b0;
		else if (wvalid_i && wready_o && wlast_i)
			bvalid_o <= 1'b1;
	end
endmodule // axi_wr_model

/* dma_channel_instr_exec.sv */
// Behaviour
// - store-single loop end: run on Single, exit on Burst
// - burst loop end: exit on Single, run on Burst
// - unqualified loop end always processed
// - set final flag, latch kind on wait
// - jump back by eight-bit offset
// - counted bit picks exit criterion
// - counter select bit picks loop counter
// - move writes source, control or destination
// - no-op only advances program counter
// - read barrier waits for loads to finish
// - event index raises event or interrupt
// - unimplemented event index aborts thread
// - store bursts to destination, then increments
// - single store: length one or no-op
// - burst store: no-op on Single
// - unqualified store always performed
// - burst starts only with full data
// - notify peripheral after write response
// - notify store: periph field, bs qualifier
// - counted end: zero exits, else decrement
// - endless end: jump until final flag
module dma_channel_instr_exec (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// instruction stream
	input  wire logic        instr_valid_i,
	input  wire logic [47:0] instr_i,
	input  wire logic        instr_mgr_i,
	output logic             instr_ready_o,
	output logic [31:0]      pc_o,
	output logic             fault_o,
	// peripheral side
	input  wire logic        periph_req_i,
	input  wire logic        periph_burst_i,
	input  wire logic        periph_last_req_i,
	output logic             periph_ack_valid_o,
	output logic [1:0]       periph_ack_type_o,
	output logic [4:0]       periph_ack_num_o,
	// load side status and events
	input  wire logic        rd_busy_i,
	output logic [31:0]      event_o,
	output logic [31:0]      irq_o,
	// fifo and axi write channels
	input  wire logic [4:0]  fifo_count_i,
	input  wire logic [31:0] fifo_data_i,
	output logic             fifo_rd_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      awaddr_o,
	output logic [3:0]       awlen_o,
	output logic [2:0]       awsize_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	output logic [31:0]      wdata_o,
	output logic             wlast_o,
	output logic             bready_o,
	input  wire logic        bvalid_i,
	input  wire logic [1:0]  bresp_i
);
	dma_exec_pkg::exec_state_t state_r;
	logic [31:0] src_addr_reg_r;
	logic [31:0] dest_addr_reg_r;
	logic [31:0] chan_ctrl_reg_r;
	logic [7:0]  lc0_r;
	logic [7:0]  lc1_r;
	logic [31:0] inten_r;
	logic        run_r;
	logic        req_kind_flag_r;   // 1 = Burst
	logic        final_req_flag_r;
	logic        notify_r;
	logic [4:0]  notify_num_r;
	logic        wb_hit;
	logic        wb_wr;
	logic [31:0] wb_rdata;
	logic        accept;
	logic [7:0]  op;
	logic        is_nop;
	logic        is_rmb;
	logic        is_sev;
	logic        is_mov;
	logic        is_st;
	logic        is_stp;
	logic        is_wfp;
	logic        is_lpe;
	logic        chan_only;
	logic        legal;
	logic        st_go;
	logic        st_single;
	logic        bad_event;
	logic [4:0]  ev_idx;
	logic [31:0] ev_onehot;
	logic [31:0] pc_step;
	logic [2:0]  dst_size;
	logic [3:0]  dst_len;
	logic [3:0]  st_len;
	logic [31:0] st_bytes;
	logic        lp_jump;
	logic        lp_dec0;
	logic        lp_dec1;
	logic        lp_exit_endless;

	store_if st_bus ();

	// ==========================================================
	// decode
	assign op        = instr_i[7:0];
	assign is_nop    = (op == dma_exec_pkg::OP_NOP);
	assign is_rmb    = (op == dma_exec_pkg::OP_RMB);
	assign is_sev    = (op == dma_exec_pkg::OP_SEV);
	assign is_mov    = (op == dma_exec_pkg::OP_MOV);
	assign is_st     = (op[7:2] == dma_exec_pkg::OP_ST_GRP);
	assign is_stp    = (op[7:2] == dma_exec_pkg::OP_STP_GRP) && op[dma_exec_pkg::BIT_X];
	assign is_wfp    = (op[7:2] == dma_exec_pkg::OP_WFP_GRP);
	assign is_lpe    = !is_stp && (op[7:5] == dma_exec_pkg::OP_LPE_HI) &&
	                   op[dma_exec_pkg::BIT_LPE_MARK];
	// manager may only run the no-op and event ops
	assign chan_only = is_rmb || is_mov || is_st || is_stp || is_wfp || is_lpe;
	assign legal     = is_nop || is_sev || (chan_only && !instr_mgr_i);
	assign ev_idx    = instr_i[dma_exec_pkg::IDX_LSB +: 5];
	assign ev_onehot = 32'h1 << ev_idx;
	assign bad_event = is_sev && ({1'b0, ev_idx} >= dma_exec_pkg::NUM_EVENTS);

	// ==========================================================
	// store qualification: x and bs both clear always, x set kind must match bs
	always_comb begin
		st_go     = !op[dma_exec_pkg::BIT_BS] && !op[dma_exec_pkg::BIT_X];
		st_single = 1'b0;
		if (is_stp || op[dma_exec_pkg::BIT_X]) begin
			if (op[dma_exec_pkg::BIT_BS]) begin
				st_go = req_kind_flag_r;
			end else begin
				st_go     = !req_kind_flag_r;
				st_single = 1'b1;
			end
		end
	end

	// ==========================================================
	// burst shape taken from the channel control word
	assign dst_size = chan_ctrl_reg_r[dma_exec_pkg::CCR_DST_SIZE_LSB +: 3];
	assign dst_len  = chan_ctrl_reg_r[dma_exec_pkg::CCR_DST_LEN_LSB +: 4];
	assign st_len   = st_single ? 4'h0 : dst_len;
	assign st_bytes = ({28'h0, st_len} + 32'h1) << dst_size;

	always_comb begin
		pc_step = dma_exec_pkg::LEN_1;
		if (is_mov)
			pc_step = dma_exec_pkg::LEN_6;
		else if (is_sev || is_stp || is_wfp || is_lpe)
			pc_step = dma_exec_pkg::LEN_2;
	end

	assign accept        = instr_valid_i && instr_ready_o;
	assign instr_ready_o = run_r && (state_r == dma_exec_pkg::EX_FETCH);
	assign fault_o       = (state_r == dma_exec_pkg::EX_FAULT);

	loop_eval u_loop (
		.op_i           (instr_i[15:0]),
		.lc0_i          (lc0_r),
		.lc1_i          (lc1_r),
		.final_i        (final_req_flag_r),
		.burst_i        (req_kind_flag_r),
		.jump_o         (lp_jump),
		.dec0_o         (lp_dec0),
		.dec1_o         (lp_dec1),
		.exit_endless_o (lp_exit_endless)
	);

	// store launch, issued in the accept cycle
	assign st_bus.start = accept && legal && (is_st || is_stp) && st_go;
	assign st_bus.addr  = dest_addr_reg_r;
	assign st_bus.len   = st_len;
	assign st_bus.size  = dst_size;

	store_engine u_store (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.st           (st_bus),
		.fifo_count_i (fifo_count_i),
		.fifo_data_i  (fifo_data_i),
		.fifo_rd_o    (fifo_rd_o),
		.awvalid_o    (awvalid_o),
		.awready_i    (awready_i),
		.awaddr_o     (awaddr_o),
		.awlen_o      (awlen_o),
		.awsize_o     (awsize_o),
		.wvalid_o     (wvalid_o),
		.wready_i     (wready_i),
		.wdata_o      (wdata_o),
		.wlast_o      (wlast_o),
		.bready_o     (bready_o),
		.bvalid_i     (bvalid_i),
		.bresp_i      (bresp_i)
	);

	// ==========================================================
	// sequencer: stalls on store, barrier and peripheral wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= dma_exec_pkg::EX_FETCH;
		end else begin
			unique case (state_r)
				dma_exec_pkg::EX_FETCH: begin
					if (accept) begin
						if (!legal || bad_event)
							state_r <= dma_exec_pkg::EX_FAULT;
						else if (st_bus.start)
							state_r <= dma_exec_pkg::EX_STORE;
						else if (is_rmb)
							state_r <= dma_exec_pkg::EX_RMB;
						else if (is_wfp)
							state_r <= dma_exec_pkg::EX_WFP;
					end
				end
				dma_exec_pkg::EX_STORE: begin
					if (st_bus.done)
						state_r <= st_bus.err ? dma_exec_pkg::EX_FAULT
						                      : dma_exec_pkg::EX_FETCH;
				end
				dma_exec_pkg::EX_RMB: begin
					if (!rd_busy_i)
						state_r <= dma_exec_pkg::EX_FETCH;
				end
				dma_exec_pkg::EX_WFP: begin
					if (periph_req_i)
						state_r <= dma_exec_pkg::EX_FETCH;
				end
				dma_exec_pkg::EX_FAULT: begin
					if (wb_wr && adr_i == dma_exec_pkg::REG_CTRL &&
					    sel_i[0] && dat_i[dma_exec_pkg::CTRL_CLR])
						state_r <= dma_exec_pkg::EX_FETCH;
				end
				default: state_r <= dma_exec_pkg::EX_FAULT;
			endcase
		end
	end

	// ==========================================================
	// program counter: no-op and skipped ops only step forward
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_o <= dma_exec_pkg::RST_WORD;
		end else if (accept && legal && !bad_event) begin
			if (is_lpe && lp_jump)
				pc_o <= pc_o - {24'h0, instr_i[dma_exec_pkg::JUMP_LSB +: 8]};
			else
				pc_o <= pc_o + pc_step;
		end else if (wb_wr && adr_i == dma_exec_pkg::REG_PC) begin
			pc_o <= dat_i;
		end
	end

	// ==========================================================
	// address and control registers: execution beats the bus
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_addr_reg_r  <= dma_exec_pkg::RST_WORD;
			dest_addr_reg_r <= dma_exec_pkg::RST_WORD;
			chan_ctrl_reg_r <= dma_exec_pkg::RST_WORD;
		end else if (accept && legal && is_mov) begin
			unique case (instr_i[dma_exec_pkg::RD_LSB +: 3])
				dma_exec_pkg::RD_SRC:  src_addr_reg_r  <= instr_i[dma_exec_pkg::IMM_LSB +: 32];
				dma_exec_pkg::RD_CTRL: chan_ctrl_reg_r <= instr_i[dma_exec_pkg::IMM_LSB +: 32];
				dma_exec_pkg::RD_DST:  dest_addr_reg_r <= instr_i[dma_exec_pkg::IMM_LSB +: 32];
				default: ;
			endcase
		end else if (st_bus.start && chan_ctrl_reg_r[dma_exec_pkg::CCR_DST_INC]) begin
			dest_addr_reg_r <= dest_addr_reg_r + st_bytes;
		end else if (wb_wr) begin
			unique case (adr_i)
				dma_exec_pkg::REG_SRC: src_addr_reg_r  <= dat_i;
				dma_exec_pkg::REG_DST: dest_addr_reg_r <= dat_i;
				dma_exec_pkg::REG_CCR: chan_ctrl_reg_r <= dat_i;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// loop counters and software controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lc0_r   <= 8'h00;
			lc1_r   <= 8'h00;
			inten_r <= dma_exec_pkg::RST_WORD;
			run_r   <= 1'b0;
		end else begin
			if (accept && legal && is_lpe && lp_dec0)
				lc0_r <= lc0_r - 8'h01;
			else if (wb_wr && adr_i == dma_exec_pkg::REG_LC0 && sel_i[0])
				lc0_r <= dat_i[7:0];
			if (accept && legal && is_lpe && lp_dec1)
				lc1_r <= lc1_r - 8'h01;
			else if (wb_wr && adr_i == dma_exec_pkg::REG_LC1 && sel_i[0])
				lc1_r <= dat_i[7:0];
			if (wb_wr && adr_i == dma_exec_pkg::REG_INTEN)
				inten_r <= dat_i;
			if (wb_wr && adr_i == dma_exec_pkg::REG_CTRL && sel_i[0])
				run_r <= dat_i[dma_exec_pkg::CTRL_RUN];
		end
	end

	// ==========================================================
	// request flags; a last request arriving during the clear wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_kind_flag_r  <= 1'b0;
			final_req_flag_r <= 1'b0;
		end else begin
			if (state_r == dma_exec_pkg::EX_WFP && periph_req_i)
				req_kind_flag_r <= periph_burst_i;
			if (periph_req_i && periph_last_req_i)
				final_req_flag_r <= 1'b1;
			else if (accept && legal && is_lpe && lp_exit_endless)
				final_req_flag_r <= 1'b0;
		end
	end

	// ==========================================================
	// send event: enable bit picks interrupt over event, one-cycle pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_o <= 32'h0;
			irq_o   <= 32'h0;
		end else begin
			event_o <= 32'h0;
			irq_o   <= 32'h0;
			if (accept && legal && is_sev && !bad_event) begin
				if (inten_r[ev_idx])
					irq_o <= ev_onehot;
				else
					event_o <= ev_onehot;
			end
		end
	end

	// ==========================================================
	// peripheral notify only after the write response is back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			notify_r           <= 1'b0;
			notify_num_r       <= 5'h0;
			periph_ack_valid_o <= 1'b0;
			periph_ack_type_o  <= dma_exec_pkg::ACK_SINGLE;
			periph_ack_num_o   <= 5'h0;
		end else begin
			periph_ack_valid_o <= 1'b0;
			if (st_bus.start) begin
				notify_r     <= is_stp;
				notify_num_r <= ev_idx;
			end
			if (st_bus.done && notify_r) begin
				periph_ack_valid_o <= 1'b1;
				periph_ack_num_o   <= notify_num_r;
				periph_ack_type_o  <= req_kind_flag_r ? dma_exec_pkg::ACK_BURST
				                                      : dma_exec_pkg::ACK_SINGLE;
			end
		end
	end

	// ==========================================================
	// wishbone slave: ack one cycle after strobe, write at the ack edge
	assign wb_hit = cyc_i && stb_i;
	assign wb_wr  = wb_hit && we_i && ack_o;

	always_comb begin
		unique case (adr_i)
			dma_exec_pkg::REG_CTRL:   wb_rdata = {31'h0, run_r};
			dma_exec_pkg::REG_STATUS: wb_rdata = {26'h0, final_req_flag_r, req_kind_flag_r,
			                                      notify_r, state_r};
			dma_exec_pkg::REG_SRC:    wb_rdata = src_addr_reg_r;
			dma_exec_pkg::REG_DST:    wb_rdata = dest_addr_reg_r;
			dma_exec_pkg::REG_CCR:    wb_rdata = chan_ctrl_reg_r;
			dma_exec_pkg::REG_LC0:    wb_rdata = {24'h0, lc0_r};
			dma_exec_pkg::REG_LC1:    wb_rdata = {24'h0, lc1_r};
			dma_exec_pkg::REG_INTEN:  wb_rdata = inten_r;
			dma_exec_pkg::REG_PC:     wb_rdata = pc_o;
			default:                  wb_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= wb_hit && !ack_o;
			if (wb_hit && !ack_o)
				dat_o <= wb_rdata;
		end
	end
endmodule // dma_channel_instr_exec

/* dma_exec_pkg.sv */
package dma_exec_pkg;

	// ==========================================================
	// opcode bytes and opcode groups
	localparam logic [7:0] OP_NOP       = 8'h18;
	localparam logic [7:0] OP_RMB       = 8'h12;
	localparam logic [7:0] OP_WMB       = 8'h13;
	localparam logic [7:0] OP_SEV       = 8'h34;
	localparam logic [7:0] OP_MOV       = 8'hBC;
	localparam logic [5:0] OP_ST_GRP    = 6'h02;  // op[7:2], bs and x below
	localparam logic [5:0] OP_STP_GRP   = 6'h0A;  // op[7:2], op[0] set
	localparam logic [5:0] OP_WFP_GRP   = 6'h0C;  // op[7:2]
	localparam logic [2:0] OP_LPE_HI    = 3'h1;   // op[7:5], op[3] set

	// ==========================================================
	// field positions inside the instruction word
	localparam int BIT_X        = 0;
	localparam int BIT_BS       = 1;
	localparam int BIT_LC       = 2;
	localparam int BIT_LPE_MARK = 3;
	localparam int BIT_NF       = 4;
	localparam int JUMP_LSB     = 8;
	localparam int IDX_LSB      = 11;
	localparam int RD_LSB       = 8;
	localparam int IMM_LSB      = 16;

	// move targets
	localparam logic [2:0] RD_SRC  = 3'h0;
	localparam logic [2:0] RD_CTRL = 3'h1;
	localparam logic [2:0] RD_DST  = 3'h2;

	// instruction lengths in bytes
	localparam logic [31:0] LEN_1 = 32'h1;
	localparam logic [31:0] LEN_2 = 32'h2;
	localparam logic [31:0] LEN_6 = 32'h6;

	// ==========================================================
	// channel control fields used by the store path
	localparam int CCR_DST_INC      = 14;
	localparam int CCR_DST_SIZE_LSB = 15;
	localparam int CCR_DST_LEN_LSB  = 18;

	// ==========================================================
	// register offsets and reset values
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_SRC    = 8'h08;
	localparam logic [7:0]  REG_DST    = 8'h0C;
	localparam logic [7:0]  REG_CCR    = 8'h10;
	localparam logic [7:0]  REG_LC0    = 8'h14;
	localparam logic [7:0]  REG_LC1    = 8'h18;
	localparam logic [7:0]  REG_INTEN  = 8'h1C;
	localparam logic [7:0]  REG_PC     = 8'h20;
	localparam logic [31:0] RST_WORD   = 32'h0;
	localparam int          CTRL_RUN   = 0;
	localparam int          CTRL_CLR   = 1;

	// configured event count and peripheral acknowledge codes
	localparam logic [5:0] NUM_EVENTS = 6'h10;
	localparam logic [1:0] ACK_SINGLE = 2'h0;
	localparam logic [1:0] ACK_BURST  = 2'h1;

	// ==========================================================
	// state encodings
	typedef enum logic [2:0] {
		EX_FETCH = 3'b000,
		EX_STORE = 3'b001,
		EX_RMB   = 3'b010,
		EX_WFP   = 3'b011,
		EX_FAULT = 3'b100
	} exec_state_t;

	typedef enum logic [2:0] {
		SE_IDLE = 3'b000,
		SE_FILL = 3'b001,
		SE_ADDR = 3'b010,
		SE_DATA = 3'b011,
		SE_RESP = 3'b100
	} store_state_t;

endpackage

/* dma_exec_properties.sv */
module dma_exec_checker (
	input logic        clk_i, rst_i, cyc_i, stb_i, ack_o, instr_valid_i, instr_ready_o,
	input logic        fault_o, rd_busy_i, fifo_rd_o, awvalid_o, awready_i, wvalid_o,
	input logic        wready_i, bvalid_i, bready_o, periph_ack_valid_o,
	input logic [47:0] instr_i,
	input logic [31:0] pc_o, event_o, irq_o, fifo_data_i, wdata_o,
	input logic [4:0]  fifo_count_i,
	input logic [3:0]  awlen_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// bus and instruction stream
	property p_ack; $rose(ack_o) |-> $past(cyc_i && stb_i) ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack without request");
	property p_nop; instr_valid_i && instr_ready_o && instr_i[7:0] == dma_exec_pkg::OP_NOP
		|=> pc_o == $past(pc_o) + 32'h1; endproperty
	a_nop: assert property (p_nop) else $error("no-op pc step wrong");
	property p_rmb; instr_valid_i && instr_ready_o && rd_busy_i
		&& instr_i[7:0] == dma_exec_pkg::OP_RMB |=> !instr_ready_o; endproperty
	a_rmb: assert property (p_rmb) else $error("barrier did not stall");
	property p_evt; $onehot0(event_o) && $onehot0(irq_o) && (event_o & irq_o) == 32'h0;
	endproperty
	a_evt: assert property (p_evt) else $error("event and irq overlap");
	property p_fault; fault_o |-> !instr_ready_o; endproperty
	a_fault: assert property (p_fault) else $error("aborted thread still fetches");
	// ==========================================================
	// store path
	property p_fill; $rose(awvalid_o) |-> fifo_count_i > {1'b0, awlen_o}; endproperty
	a_fill: assert property (p_fill) else $error("burst started short of data");
	property p_pop; wvalid_o && wready_i |-> fifo_rd_o && wdata_o == fifo_data_i; endproperty
	a_pop: assert property (p_pop) else $error("beat not taken from fifo");
	property p_aw; awvalid_o && !awready_i |=> awvalid_o; endproperty
	a_aw: assert property (p_aw) else $error("address dropped early");
	property p_notify; $rose(periph_ack_valid_o) |-> $past(bvalid_i && bready_o, 2); endproperty
	a_notify: assert property (p_notify) else $error("notify before response");
endmodule // dma_exec_checker

bind dma_channel_instr_exec dma_exec_checker i_chk (.*);

/* loop_eval.sv */
module loop_eval (
	input  wire logic [15:0] op_i,
	input  wire logic [7:0]  lc0_i,
	input  wire logic [7:0]  lc1_i,
	input  wire logic        final_i,
	input  wire logic        burst_i,
	output logic             jump_o,
	output logic             dec0_o,
	output logic             dec1_o,
	output logic             exit_endless_o
);
	logic       pass;
	logic [7:0] cnt;

	// ==========================================================
	// qualifier check and exit criterion
	always_comb begin
		// x clear: always; x set: request kind must match bs
		pass           = !op_i[dma_exec_pkg::BIT_X] ||
		                 (op_i[dma_exec_pkg::BIT_BS] == burst_i);
		cnt            = op_i[dma_exec_pkg::BIT_LC] ? lc1_i : lc0_i;
		jump_o         = 1'b0;
		dec0_o         = 1'b0;
		dec1_o         = 1'b0;
		exit_endless_o = 1'b0;
		if (pass) begin
			if (op_i[dma_exec_pkg::BIT_NF]) begin
				// counted loop: zero count leaves
				if (cnt != 8'h00) begin
					jump_o = 1'b1;
					dec0_o = !op_i[dma_exec_pkg::BIT_LC];
					dec1_o = op_i[dma_exec_pkg::BIT_LC];
				end
			end else begin
				jump_o         = !final_i;
				exit_endless_o = final_i;
			end
		end
	end
endmodule // loop_eval

/* store_engine.sv */
module store_engine (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	store_if.eng             st,
	input  wire logic [4:0]  fifo_count_i,
	input  wire logic [31:0] fifo_data_i,
	output logic             fifo_rd_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      awaddr_o,
	output logic [3:0]       awlen_o,
	output logic [2:0]       awsize_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	output logic [31:0]      wdata_o,
	output logic             wlast_o,
	output logic             bready_o,
	input  wire logic        bvalid_i,
	input  wire logic [1:0]  bresp_i
);
	dma_exec_pkg::store_state_t state_r;
	logic [3:0]                 beat_r;

	// handshakes come straight from state, data straight from the fifo head
	assign awvalid_o = (state_r == dma_exec_pkg::SE_ADDR);
	assign wvalid_o  = (state_r == dma_exec_pkg::SE_DATA);
	assign bready_o  = (state_r == dma_exec_pkg::SE_RESP);
	assign wlast_o   = wvalid_o && (beat_r == awlen_o);
	assign wdata_o   = fifo_data_i;
	assign fifo_rd_o = wvalid_o && wready_i;

	// ==========================================================
	// burst sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r  <= dma_exec_pkg::SE_IDLE;
			beat_r   <= 4'h0;
			awaddr_o <= 32'h0;
			awlen_o  <= 4'h0;
			awsize_o <= 3'h0;
			st.done  <= 1'b0;
			st.err   <= 1'b0;
		end else begin
			st.done <= 1'b0;
			unique case (state_r)
				dma_exec_pkg::SE_IDLE: begin
					if (st.start) begin
						awaddr_o <= st.addr;
						awlen_o  <= st.len;
						awsize_o <= st.size;
						beat_r   <= 4'h0;
						state_r  <= dma_exec_pkg::SE_FILL;
					end
				end
				dma_exec_pkg::SE_FILL: begin
					// whole burst must already sit in the fifo
					if (fifo_count_i > {1'b0, awlen_o})
						state_r <= dma_exec_pkg::SE_ADDR;
				end
				dma_exec_pkg::SE_ADDR: begin
					if (awready_i)
						state_r <= dma_exec_pkg::SE_DATA;
				end
				dma_exec_pkg::SE_DATA: begin
					if (wready_i) begin
						beat_r <= beat_r + 4'h1;
						if (wlast_o)
							state_r <= dma_exec_pkg::SE_RESP;
					end
				end
				dma_exec_pkg::SE_RESP: begin
					if (bvalid_i) begin
						st.done <= 1'b1;
						st.err  <= bresp_i[1];
						state_r <= dma_exec_pkg::SE_IDLE;
					end
				end
			endcase
		end
	end
endmodule // store_engine

/* store_if.sv */
interface store_if;
	logic        start;
	logic [31:0] addr;
	logic [3:0]  len;
	logic [2:0]  size;
	logic        done;
	logic        err;

	modport ctl (output start, output addr, output len, output size,
	             input done, input err);
	modport eng (input start, input addr, input len, input size,
	             output done, output err);
endinterface

/* tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
	logic instr_valid_i = 1'b0, instr_mgr_i = 1'b0, instr_ready_o, fault_o, fifo_rd_o;
	logic periph_req_i = 1'b0, periph_burst_i = 1'b0, periph_last_req_i = 1'b0;
	logic periph_ack_valid_o, rd_busy_i = 1'b0, awvalid_o, awready_i, wvalid_o, wready_i;
	logic wlast_o, bready_o, bvalid_i;
	logic [1:0]  periph_ack_type_o, bresp_i;
	logic [2:0]  awsize_o;
	logic [3:0]  awlen_o, len_seen, sel_i = 4'hF;
	logic [4:0]  fifo_count_i = 5'h00, periph_ack_num_o;
	logic [6:0]  ack_seen = 7'h00;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, pc_o, event_o, irq_o, awaddr_o, wdata_o, rd_val, base;
	logic [31:0] fifo_data_i = 32'hA5A5_0F0F, evt_seen = 32'h0, irq_seen = 32'h0, dst = 32'h1010;
	logic [47:0] instr_i = 48'h0;
	logic [47:0] st_v [6] = '{48'h09, 48'h09, 48'h0B, 48'h0B, 48'h09, 48'h0B};
	logic [31:0] lp_v [6][3] = '{'{32'h1038, 32'h1, 32'hFFFF_FFF0}, '{32'h1038, 32'h0, 32'h2},
		'{32'h103B, 32'h3, 32'h2}, '{32'h1039, 32'h3, 32'hFFFF_FFF0},
		'{32'h083C, 32'h2, 32'hFFFF_FFF8}, '{32'h102C, 32'h0, 32'hFFFF_FFF0}};
	int n_fail = 0, cmp_count = 0, cyc_n = 0;
	dma_channel_instr_exec i_dut (.*);
	axi_wr_model i_axi (.clk_i(clk_i), .rst_i(rst_i), .awvalid_i(awvalid_o), .wvalid_i(wvalid_o),
		.wlast_i(wlast_o), .bready_i(bready_o), .awlen_i(awlen_o), .awready_o(awready_i),
		.wready_o(wready_i), .bvalid_o(bvalid_i), .bresp_o(bresp_i), .len_seen_o(len_seen));
	always #12.5 clk_i = ~clk_i;
	// ==========================================================
	// pulse capture and hang guard; mid-cycle so pulses are settled before the next check
	always @(negedge clk_i) begin
		evt_seen |= event_o;
		irq_seen |= irq_o;
		if (periph_ack_valid_o)
			ack_seen = {periph_ack_type_o, periph_ack_num_o};
		if (++cyc_n == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// classic single cycle; ack judged at the sampling edge only
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd_val = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wait_ready();
		do @(posedge clk_i); while (instr_ready_o !== 1'b1 && fault_o !== 1'b1);
	endtask
	task automatic run(input logic [47:0] op, input logic mgr, input logic w);
		instr_valid_i <= 1'b1;
		instr_i <= op;
		instr_mgr_i <= mgr;
		do @(posedge clk_i); while (instr_ready_o !== 1'b1);
		instr_valid_i <= 1'b0;
		if (w)
			wait_ready();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, 8'h3C, 32'h1234_5678);
		wb(1'b0, 8'h3C, 32'h0);
		chk("unmapped", rd_val, 32'h0);
		wb(1'b1, dma_exec_pkg::REG_PC, 32'h100);
		wb(1'b1, dma_exec_pkg::REG_CTRL, 32'h1);
		wb(1'b1, dma_exec_pkg::REG_INTEN, 32'h4);
		run(48'h18, 1'b1, 1'b1);
		run(48'h18, 1'b0, 1'b1);
		chk("pc", pc_o, 32'h102);
		run({32'h55, 8'h00, 8'hBC}, 1'b0, 1'b1);
		run({32'h000D_4000, 8'h01, 8'hBC}, 1'b0, 1'b1);
		run({32'h1000, 8'h02, 8'hBC}, 1'b0, 1'b1);
		wb(1'b0, dma_exec_pkg::REG_CCR, 32'h0);
		chk("ccr", rd_val, 32'h000D_4000);
		// store held back until four beats wait in the fifo
		run(48'h08, 1'b0, 1'b0);
		repeat (6) @(posedge clk_i);
		chk("awvalid", awvalid_o, 32'h0);
		fifo_count_i <= 5'h04;
		wait_ready();
		chk("len", len_seen, 32'h3);
		chk("awaddr", awaddr_o, 32'h1000);
		for (int i = 0; i < 6; i++) begin
			periph_req_i <= 1'b1;
			periph_burst_i <= (i < 3);
			run(48'h30, 1'b0, 1'b1);
			base = pc_o;
			run(st_v[i], 1'b0, 1'b1);
			dst += (i == 2) ? 32'h10 : (i == 4) ? 32'h4 : 32'h0;
			wb(1'b0, dma_exec_pkg::REG_DST, 32'h0);
			chk("dst", rd_val, dst);
			chk("pc", pc_o, base + 32'h1);
		end
		chk("len", len_seen, 32'h0);
		run(48'h2929, 1'b0, 1'b1);
		chk("notify", ack_seen, {dma_exec_pkg::ACK_SINGLE, 5'h05});
		// loop ends; the endless one carries no qualifier and no opening op
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, i == 4 ? dma_exec_pkg::REG_LC1 : dma_exec_pkg::REG_LC0, lp_v[i][1]);
			base = pc_o;
			run(lp_v[i][0], 1'b0, 1'b1);
			chk("loop pc", pc_o, base + lp_v[i][2]);
		end
		periph_last_req_i <= 1'b1;
		@(posedge clk_i);
		periph_last_req_i <= 1'b0;
		base = pc_o;
		run(48'h102C, 1'b0, 1'b1);
		chk("final exit", pc_o, base + 32'h2);
		run(48'h1034, 1'b0, 1'b1);
		run(48'h0834, 1'b1, 1'b1);
		chk("irq", irq_seen, 32'h4);
		chk("event", evt_seen, 32'h2);
		run(48'hA034, 1'b0, 1'b1);
		chk("fault", fault_o, 32'h1);
		wb(1'b1, dma_exec_pkg::REG_CTRL, 32'h3);
		rd_busy_i <= 1'b1;
		run(48'h12, 1'b0, 1'b0);
		repeat (4) @(posedge clk_i);
		chk("barrier", instr_ready_o, 32'h0);
		rd_busy_i <= 1'b0;
		wait_ready();
		chk("barrier", instr_ready_o, 32'h1);
		tally_and_finish();
	end
endmodule // tb
